/* File: core/ssdr_core.sv */
`timescale 1ns/100ps

module ssdr_core #(
  parameter int unsigned ADDR_W = 8  // Register address width.
) (
  input  wire logic              core_clk_i,   // Core clock.
  input  wire logic              srst_i,       // Synchronous reset, active high.
  input  wire logic [ADDR_W-1:0] addr_i,       // Register address.
  input  wire logic [7:0]        wdata_i,      // Register write data.
  input  wire logic              wr_i,         // Write strobe.
  input  wire logic              rd_i,         // Read strobe.
  output logic      [7:0]        rdata_o,      // Read data, one cycle after the strobe.
  output logic                   irq_o,        // Interrupt request, level.
  input  wire logic              sck_i,        // Serial clock pin, input side.
  output logic                   sck_o,        // Serial clock pin, output side.
  output logic                   sck_oe_n_o,   // Serial clock drive enable, active low.
  input  wire logic              mosi_i,       // Controller-out pin, input side.
  output logic                   mosi_o,       // Controller-out pin, output side.
  output logic                   mosi_oe_n_o,  // Controller-out drive enable, active low.
  input  wire logic              miso_i,       // Peripheral-out pin, input side.
  output logic                   miso_o,       // Peripheral-out pin, output side.
  output logic                   miso_oe_n_o,  // Peripheral-out drive enable, active low.
  input  wire logic              ss_n_i        // Slave select pin, active low.
);

  // The decode compares against 8-bit addresses, so narrower buses cannot serve.
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  // Pin synchronisers: index 0 clock, 1 controller-out, 2 peripheral-out, 3 select.
  logic [3:0] pin_raw;     // Raw pin levels.
  logic [3:0] pin_s1_r;    // First synchroniser stage.
  logic [3:0] pin_s2_r;    // Second synchroniser stage.
  logic       sck_d_r;     // Delayed synchronised clock for edge finding.

  assign pin_raw = {ss_n_i, miso_i, mosi_i, sck_i};

  // Every pin passes two flops; the first stage feeds only the second.
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        pin_s1_r[i] <= 1'b1;
        pin_s2_r[i] <= 1'b1;
      end else begin
        pin_s1_r[i] <= pin_raw[i];
        pin_s2_r[i] <= pin_s1_r[i];
      end
    end
  end

  // Remember the last synchronised clock level to find slave edges.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sck_d_r <= 1'b1;  // Matches the synchroniser reset, so no false edge follows reset.
    end else begin
      sck_d_r <= pin_s2_r[0];
    end
  end

  // Registers.
  logic [7:0]             ctrl_r;       // Serial control register.
  logic                   done_r;       // Transfer done flag.
  logic                   write_collision_flag_r;       // Write collision flag.
  logic                   ovr_r;        // Overrun flag.
  logic                   mode_fault_flag_r;       // Mode fault flag.
  logic                   out_dis_r;    // Output disable.
  logic                   sel_soft_r;   // Software select control.
  logic                   sel_lvl_r;    // Software select level.
  logic                   arm_r;        // Status read seen, waiting for a data access.
  logic                   mode_fault_flag_arm_r;   // Status read with fault set, waiting for a control write.
  logic [ssdr_pkg::EVT_W-1:0] evt_sts_r;  // Sticky event status.
  logic [ssdr_pkg::EVT_W-1:0] evt_mask_r; // Event mask.
  logic [7:0]             rx_buf_r;     // Receive read buffer.
  logic [7:0]             rx_sh_r;      // Receive shift register.
  logic [7:0]             tx_sh_r;      // Transmit shift register.
  logic [2:0]             bit_cnt_r;    // Completed serial periods in this byte.
  logic [6:0]             half_cnt_r;   // Master half-period counter.
  logic                   sck_gen_r;    // Master serial clock level.
  ssdr_pkg::ssdr_xfer_e   xfer_st_r;    // Transfer engine state.
  logic [7:0]             rdata_r;      // Registered read data.
  logic                   irq_r;        // Registered interrupt.

  // Decoded strobes.
  logic data_wr, data_rd, ctrl_wr, csr_wr, stat_rd, sts_rd, mask_wr;
  assign data_wr = wr_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_DATA));
  assign data_rd = rd_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_DATA));
  assign ctrl_wr = wr_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_CTRL));
  assign csr_wr  = wr_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_CSR));
  assign stat_rd = rd_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_CSR));
  assign sts_rd  = rd_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_EVT_STS));
  assign mask_wr = wr_i && (addr_i == ADDR_W'(ssdr_pkg::ADDR_EVT_MASK));

  // Mode and select.
  logic is_master, port_en, cpol, cpha, ss_int, slave_sel, busy, data_acc;
  assign is_master = ctrl_r[ssdr_pkg::CTRL_MASTER];
  assign port_en   = ctrl_r[ssdr_pkg::CTRL_PORT_EN];
  assign cpol      = ctrl_r[ssdr_pkg::CTRL_CPOL];
  assign cpha      = ctrl_r[ssdr_pkg::CTRL_CPHA];
  assign ss_int    = sel_soft_r ? sel_lvl_r : pin_s2_r[3];
  assign slave_sel = port_en && !is_master && !ss_int;
  assign busy      = (xfer_st_r == ssdr_pkg::XF_RUN);
  assign data_acc  = data_rd || data_wr;

  // Events seen by the flag logic.
  logic mode_fault_flag_evt, wr_block, write_collision_flag_evt, wr_take;
  assign mode_fault_flag_evt = port_en && is_master && !ss_int;
  assign wr_block = done_r && !arm_r;
  assign write_collision_flag_evt = data_wr && busy;
  assign wr_take  = data_wr && !busy && !wr_block;

  // Master rate selection from the divider and rate bits.
  logic [6:0] half_len;
  always_comb begin
    unique case ({ctrl_r[ssdr_pkg::CTRL_DIV_EN], ctrl_r[ssdr_pkg::CTRL_RATE_HI], ctrl_r[ssdr_pkg::CTRL_RATE_LO]})
      3'h4:    half_len = ssdr_pkg::HALF_DIV4;
      3'h0:    half_len = ssdr_pkg::HALF_DIV8;
      3'h1:    half_len = ssdr_pkg::HALF_DIV16;
      3'h6:    half_len = ssdr_pkg::HALF_DIV32;
      3'h2:    half_len = ssdr_pkg::HALF_DIV64;
      default: half_len = ssdr_pkg::HALF_DIV128;
    endcase
  end

  // Serial clock edges: made by the divider in master mode, found on the pin in slave mode.
  logic m_tog, s_tog, lead, trail, sample, shift, din, done_evt;
  logic [7:0] rx_byte;
  assign m_tog  = busy && is_master && (half_cnt_r == 7'h01);
  assign s_tog  = slave_sel && (pin_s2_r[0] != sck_d_r);
  assign lead   = is_master ? (m_tog && (sck_gen_r == cpol)) : (s_tog && (sck_d_r == cpol));
  assign trail  = is_master ? (m_tog && (sck_gen_r != cpol)) : (s_tog && (sck_d_r != cpol) && busy);
  assign sample = cpha ? trail : lead;
  // With the late phase the first leading edge only starts the byte, it does not shift.
  assign shift  = cpha ? (lead && busy && (bit_cnt_r != 3'h0)) : trail;
  assign din    = is_master ? pin_s2_r[2] : pin_s2_r[1];
  // The eighth trailing edge ends the byte.
  assign done_evt = trail && (bit_cnt_r == ssdr_pkg::LAST_BIT);
  // With the late phase the last bit arrives on the same edge that ends the byte.
  assign rx_byte  = cpha ? {rx_sh_r[6:0], din} : rx_sh_r;

  // Transfer engine state and bit counting.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      xfer_st_r <= ssdr_pkg::XF_IDLE;
      bit_cnt_r <= 3'h0;
    end else begin
      unique case (xfer_st_r)
        ssdr_pkg::XF_IDLE: begin
          bit_cnt_r <= 3'h0;
          if (is_master && port_en && wr_take && !mode_fault_flag_evt) begin
            xfer_st_r <= ssdr_pkg::XF_RUN;
          end else if (!is_master && lead) begin
            xfer_st_r <= ssdr_pkg::XF_RUN;
          end
        end
        ssdr_pkg::XF_RUN: begin
          // A fault, a deselect or a disabled port abandons the byte mid-way.
          if (mode_fault_flag_evt || !port_en || (!is_master && ss_int) || done_evt) begin
            xfer_st_r <= ssdr_pkg::XF_IDLE;
            bit_cnt_r <= 3'h0;
          end else if (trail) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
          end
        end
      endcase
    end
  end

  // Master serial clock divider; the clock rests at its idle level between bytes.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      half_cnt_r <= ssdr_pkg::HALF_DIV128;
      sck_gen_r  <= 1'b0;
    end else if (!busy || !is_master) begin
      half_cnt_r <= half_len;
      sck_gen_r  <= cpol;
    end else if (m_tog) begin
      half_cnt_r <= half_len;
      sck_gen_r  <= !sck_gen_r;
    end else begin
      half_cnt_r <= half_cnt_r - 7'h01;
    end
  end

  // Shift registers: a data write goes straight into the transmit shifter.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
    end else begin
      if (wr_take) begin
        tx_sh_r <= wdata_i;
      end else if (shift) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
      if (sample) begin
        rx_sh_r <= {rx_sh_r[6:0], din};
      end
    end
  end

  // Read buffer: loaded only when the done flag rises, so an overrun keeps the old byte.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_buf_r <= 8'h00;
    end else if (done_evt && !done_r) begin
      rx_buf_r <= rx_byte;
    end
  end

  // Done and collision flags and their shared status-then-data clearing sequence.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      arm_r  <= 1'b0;
    end else begin
      if (done_evt) begin
        done_r <= 1'b1;
      end else if (arm_r && data_acc) begin
        done_r <= 1'b0;
      end
      if (write_collision_flag_evt) begin
        write_collision_flag_r <= 1'b1;
      end else if (arm_r && data_acc) begin
        write_collision_flag_r <= 1'b0;
      end
      if (stat_rd) begin
        arm_r <= 1'b1;
      end else if (data_acc) begin
        arm_r <= 1'b0;
      end
    end
  end

  // Overrun flag: a byte completing while done is still set; a status read clears it unless an overrun occurs in the same cycle.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ovr_r <= 1'b0;
    end else if (done_evt && done_r) begin
      ovr_r <= 1'b1;
    end else if (stat_rd) begin
      ovr_r <= 1'b0;
    end
  end

  // Mode fault flag: cleared by a status read while set, then a control write.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_fault_flag_r     <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
    end else begin
      if (mode_fault_flag_evt) begin
        mode_fault_flag_r <= 1'b1;
      end else if (mode_fault_flag_arm_r && ctrl_wr) begin
        mode_fault_flag_r <= 1'b0;
      end
      if (stat_rd && mode_fault_flag_r) begin
        mode_fault_flag_arm_r <= 1'b1;
      end else if (ctrl_wr) begin
        mode_fault_flag_arm_r <= 1'b0;
      end
    end
  end

  // Control register; a fault takes the port off the pins and drops master mode.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_r <= ssdr_pkg::CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= wdata_i;
      end
      if (mode_fault_flag_evt) begin
        ctrl_r[ssdr_pkg::CTRL_PORT_EN] <= 1'b0;
        ctrl_r[ssdr_pkg::CTRL_MASTER]  <= 1'b0;
      end
    end
  end

  // Writable low bits of the control and status register; the reserved bit is not stored.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      out_dis_r  <= ssdr_pkg::CSR_RST[ssdr_pkg::CSR_OUT_DIS];
      sel_soft_r <= ssdr_pkg::CSR_RST[ssdr_pkg::CSR_SEL_SOFT];
      sel_lvl_r  <= ssdr_pkg::CSR_RST[ssdr_pkg::CSR_SEL_LVL];
    end else if (csr_wr) begin
      out_dis_r  <= wdata_i[ssdr_pkg::CSR_OUT_DIS];
      sel_soft_r <= wdata_i[ssdr_pkg::CSR_SEL_SOFT];
      sel_lvl_r  <= wdata_i[ssdr_pkg::CSR_SEL_LVL];
    end
  end

  // Sticky event bits: an event in the cycle of a clearing read still sets the bit.
  logic [ssdr_pkg::EVT_W-1:0] evt_in;
  assign evt_in[ssdr_pkg::EVT_DONE] = done_evt;
  assign evt_in[ssdr_pkg::EVT_WRITE_COLLISION_FLAG] = write_collision_flag_evt;
  assign evt_in[ssdr_pkg::EVT_OVR]  = done_evt && done_r;
  assign evt_in[ssdr_pkg::EVT_MODE_FAULT_FLAG] = mode_fault_flag_evt;

  for (genvar e = 0; e < ssdr_pkg::EVT_W; e++) begin : g_evt
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        evt_sts_r[e] <= 1'b0;
      end else begin
        evt_sts_r[e] <= evt_in[e] || (evt_sts_r[e] && !sts_rd);
      end
    end
  end

  // Event mask register.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      evt_mask_r <= ssdr_pkg::EVT_MASK_RST;
    end else if (mask_wr) begin
      evt_mask_r <= wdata_i[ssdr_pkg::EVT_W-1:0];
    end
  end

  // One interrupt line: the done, overrun and mode fault flags gated by the enable bit, plus unmasked sticky events.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (ctrl_r[ssdr_pkg::CTRL_IRQ_EN] && (done_r || ovr_r || mode_fault_flag_r))
               || (|(evt_sts_r & evt_mask_r));
    end
  end

  // Read data, registered so that it stands in the cycle after the strobe only.
  logic [7:0] csr_val;
  assign csr_val = {done_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, 1'b0, out_dis_r, sel_soft_r, sel_lvl_r};

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !rd_i) begin
      rdata_r <= 8'h00;
    end else begin
      unique case (addr_i[7:0])
        ssdr_pkg::ADDR_DATA:     rdata_r <= rx_buf_r;
        ssdr_pkg::ADDR_CTRL:     rdata_r <= ctrl_r;
        ssdr_pkg::ADDR_CSR:      rdata_r <= csr_val;
        ssdr_pkg::ADDR_EVT_STS:  rdata_r <= {4'h0, evt_sts_r};
        ssdr_pkg::ADDR_EVT_MASK: rdata_r <= {4'h0, evt_mask_r};
        default:                 rdata_r <= 8'h00;  // Unmapped addresses read zero.
      endcase
    end
  end

  // Pin drivers; the data output is released when disabled or when the port is off.
  assign rdata_o     = rdata_r;
  assign irq_o       = irq_r;
  assign sck_o       = sck_gen_r;
  assign sck_oe_n_o  = !(port_en && is_master);
  assign mosi_o      = tx_sh_r[7];
  assign miso_o      = tx_sh_r[7];
  assign mosi_oe_n_o = !(port_en && is_master && !out_dis_r);
  // Only a selected slave drives, so several slaves can share the line.
  assign miso_oe_n_o = !(slave_sel && !out_dis_r);

  // Checks next to the logic they guard.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_stat_rd_done;
    stat_rd && done_r;
  endsequence
  sequence s_data_access;
    data_acc && !done_evt;
  endsequence

  property p_done_set;
    done_evt |=> done_r;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag did not set");

  // Software usually leaves one idle cycle between the status read and the data access.
  property p_done_clear;
    s_stat_rd_done ##1 !data_acc ##1 s_data_access |=> !done_r;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_wr_block;
    (data_wr && done_r && !arm_r) |=> $stable(tx_sh_r) || $past(shift);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("blocked write reached shifter");

  property p_write_collision_flag;
    (data_wr && busy) |=> write_collision_flag_r;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag missing");

  property p_ovr;
    (done_evt && done_r) |=> ovr_r && done_r && $stable(rx_buf_r);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_ovr_clear;
    (stat_rd && !done_evt) |=> !ovr_r;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

  property p_mode_fault_flag;
    mode_fault_flag_evt |=> mode_fault_flag_r && !ctrl_r[ssdr_pkg::CTRL_PORT_EN] && !ctrl_r[ssdr_pkg::CTRL_MASTER] && !busy;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault handling wrong");

  property p_out_dis;
    out_dis_r |-> mosi_oe_n_o && miso_oe_n_o;
  endproperty
  a_out_dis: assert property (p_out_dis) else $error("output driven while disabled");

  property p_start;
    (is_master && port_en && wr_take && !mode_fault_flag_evt && !busy) |=> busy ##1 (half_cnt_r != 7'h00);
  endproperty
  a_start: assert property (p_start) else $error("master write did not start");

  property p_rx_copy;
    (done_evt && !done_r) |=> (rx_buf_r == $past(rx_byte));
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("read buffer not loaded");

  property p_irq;
    (ctrl_r[ssdr_pkg::CTRL_IRQ_EN] && done_r) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  // Serial clock edges of the current byte, counted apart from the bit counter.
  logic [4:0] edge_cnt_r;  // Leading plus trailing edges seen so far.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || (!busy && !lead)) begin
      edge_cnt_r <= 5'h00;
    end else if (lead || trail) begin
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  // Eight periods are sixteen edges, so fifteen precede the one that ends the byte.
  property p_eight;
    done_evt |-> (edge_cnt_r == 5'h0F);
  endproperty
  a_eight: assert property (p_eight) else $error("byte length not eight");

endmodule

/* File: dv/spi_status_and_data_regs_test.sv */
`timescale 1ns/100ps
module spi_status_and_data_regs_test;
  logic       core_clk_i = 1'b0;  // Core clock.
  logic       srst_i     = 1'b1;  // Reset.
  logic       wr_i       = 1'b0;  // Write strobe.
  logic       rd_i       = 1'b0;  // Read strobe.
  logic       ld         = 1'b0;  // Slave reply load.
  logic [7:0] addr_i     = 8'h00;  // Address.
  logic [7:0] wdata_i    = 8'h00;  // Write data.
  logic [7:0] tx         = 8'h00;  // Slave reply.
  logic [7:0] rdata_o;  // Read data.
  logic [7:0] rx;  // Slave received byte.
  logic       irq_o, sck_o, mosi_o, miso_i, mosi_oe_n_o;  // Design pins.
  logic       s_sck      = 1'b0;   // Serial clock driven in slave mode.
  logic       s_mosi     = 1'b0;   // Controller-out level driven in slave mode.
  logic       ss_n       = 1'b1;   // Slave select pin, active low.
  logic [7:0] s_got      = 8'h00;  // Bits taken from the peripheral-out pin.
  logic       miso_o, miso_oe_n_o, sck_oe_n_o;  // Slave-side design pins.
  int         n_mismatch = 0;  // Mismatches.
  int         compares   = 0;  // Comparisons.
  int         cyc        = 0;  // Cycle count.
  // Free-running clock, 8 ns period.
  initial forever #4 core_clk_i = ~core_clk_i;
  // Slave-side clock and data pins toggle only in the slave-mode part; the select pin stays low from there into the mode-fault part.
  ssdr_core uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sck_i(s_sck), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n_o), .mosi_i(s_mosi), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
    .miso_i(miso_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n));
  ssdr_slave_model peer (.sck_i(sck_o), .mosi_i(mosi_o), .ld_i(ld), .tx_i(tx),
    .miso_o(miso_i), .rx_o(rx));
  // Compare and report.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read, then check the data in the following cycle.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // Arm the slave reply, then start a byte.
  task automatic go(input logic [7:0] t, input logic [7:0] d);
    tx <= t;
    ld <= 1'b1;
    wr(ssdr_pkg::ADDR_DATA, d);
    ld <= 1'b0;
  endtask
  // Act as master on the slave-mode pins: mode 0, 160 ns serial period, MSB first.
  task automatic mbyte(input logic [7:0] d);
    for (int b = 7; b >= 0; b--) begin
      @(posedge core_clk_i);
      s_mosi <= d[b];
      repeat (9) @(posedge core_clk_i);
      s_sck <= 1'b1;
      s_got <= {s_got[6:0], miso_o};
      repeat (10) @(posedge core_clk_i);
      s_sck <= 1'b0;
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short well past the expected run.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  // Done is left pending without a status read to probe the write block.
  initial begin
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rc(ssdr_pkg::ADDR_CSR, 8'h00);
    rc(ssdr_pkg::ADDR_CTRL, 8'h00);
    wr(ssdr_pkg::ADDR_CSR, 8'h03);
    wr(ssdr_pkg::ADDR_CTRL, 8'hD0);
    rc(ssdr_pkg::ADDR_CTRL, 8'hD0);
    chk({7'h00, mosi_oe_n_o}, 8'h00);
    go(8'hA5, 8'h3C);
    repeat (80) @(posedge core_clk_i);
    #1 chk({7'h00, irq_o}, 8'h01);
    wr(ssdr_pkg::ADDR_DATA, 8'h55);
    repeat (80) @(posedge core_clk_i);
    #1 chk(rx, 8'h3C);
    rc(ssdr_pkg::ADDR_CSR, 8'h83);
    rc(ssdr_pkg::ADDR_DATA, 8'hA5);
    rc(ssdr_pkg::ADDR_CSR, 8'h03);
    chk({7'h00, irq_o}, 8'h00);
    go(8'hC3, 8'h5A);
    wr(ssdr_pkg::ADDR_DATA, 8'h66);
    repeat (80) @(posedge core_clk_i);
    rc(ssdr_pkg::ADDR_CSR, 8'hC3);
    rc(ssdr_pkg::ADDR_DATA, 8'hC3);
    chk(rx, 8'h5A);
    rc(ssdr_pkg::ADDR_CSR, 8'h03);
    wr(ssdr_pkg::ADDR_CSR, 8'h07);
    repeat (2) @(posedge core_clk_i);
    #1 chk({7'h00, mosi_oe_n_o}, 8'h01);
    wr(ssdr_pkg::ADDR_CSR, 8'h02);
    repeat (4) @(posedge core_clk_i);
    rc(ssdr_pkg::ADDR_CSR, 8'h12);
    rc(ssdr_pkg::ADDR_CTRL, 8'h80);
    chk({7'h00, irq_o}, 8'h01);
    wr(ssdr_pkg::ADDR_CTRL, 8'hA0);
    rc(ssdr_pkg::ADDR_CSR, 8'h02);
    wr(ssdr_pkg::ADDR_EVT_MASK, 8'h08);
    repeat (2) @(posedge core_clk_i);
    #1 chk({7'h00, irq_o}, 8'h01);
    rc(ssdr_pkg::ADDR_EVT_STS, 8'h0B);
    rc(ssdr_pkg::ADDR_EVT_STS, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    rc(8'h30, 8'h00);
    // Slave mode, select from the pin: a second byte lands before the done flag is cleared.
    @(posedge core_clk_i);
    ss_n <= 1'b0;
    wr(ssdr_pkg::ADDR_CSR, 8'h00);
    wr(ssdr_pkg::ADDR_CTRL, 8'hC0);
    wr(ssdr_pkg::ADDR_DATA, 8'h96);
    mbyte(8'h69);
    chk(s_got, 8'h96);
    mbyte(8'h0F);
    repeat (6) @(posedge core_clk_i);
    #1 chk({6'h00, sck_oe_n_o, miso_oe_n_o}, 8'h02);
    rc(ssdr_pkg::ADDR_CSR, 8'hA0);
    rc(ssdr_pkg::ADDR_CSR, 8'h80);
    rc(ssdr_pkg::ADDR_DATA, 8'h69);
    rc(ssdr_pkg::ADDR_CSR, 8'h00);
    // Master mode with the select pin still low is a mode fault.
    wr(ssdr_pkg::ADDR_CTRL, 8'h50);
    rc(ssdr_pkg::ADDR_CSR, 8'h10);
    rc(ssdr_pkg::ADDR_CTRL, 8'h00);
    close_out();
  end
endmodule

/* File: dv/ssdr_slave_model.sv */
`timescale 1ns/100ps
// Slave on the far side, mode 0: samples on rising sck, shifts on falling sck.
module ssdr_slave_model (
  input  wire logic       sck_i,   // Serial clock from the master.
  input  wire logic       mosi_i,  // Data from the master.
  input  wire logic       ld_i,    // Rising edge loads the reply byte.
  input  wire logic [7:0] tx_i,    // Reply byte.
  output logic            miso_o,  // Data to the master.
  output logic      [7:0] rx_o     // Byte received, MSB first.
);
  logic [7:0] sh;  // Reply shifter.
  // One bit taken per serial clock period.
  always @(posedge sck_i) rx_o = {rx_o[6:0], mosi_i};
  // Refill with inverted bits so a stale line never looks valid.
  always @(negedge sck_i) sh = {sh[6:0], ~sh[7]};
  // Load the next reply between bytes.
  always @(posedge ld_i) sh = tx_i;
  assign miso_o = sh[7];
endmodule

/* File: inc/ssdr_pkg.sv */
package ssdr_pkg;

  // Register addresses on the plain register port.
  localparam logic [7:0] ADDR_DATA     = 8'h21;  // Serial data buffer.
  localparam logic [7:0] ADDR_CTRL     = 8'h22;  // Serial control.
  localparam logic [7:0] ADDR_CSR      = 8'h23;  // Serial control and status.
  localparam logic [7:0] ADDR_EVT_STS  = 8'h24;  // Sticky event status, cleared by a read.
  localparam logic [7:0] ADDR_EVT_MASK = 8'h25;  // Event mask, same layout as the event status.

  // Field positions in the serial control register.
  localparam int unsigned CTRL_IRQ_EN  = 7;  // Interrupt enable.
  localparam int unsigned CTRL_PORT_EN = 6;  // Port enable.
  localparam int unsigned CTRL_DIV_EN  = 5;  // Divisor-halving select for rate settings 00 and 10.
  localparam int unsigned CTRL_MASTER  = 4;  // Master select.
  localparam int unsigned CTRL_CPOL    = 3;  // Serial clock idle level.
  localparam int unsigned CTRL_CPHA    = 2;  // Serial clock capture phase.
  localparam int unsigned CTRL_RATE_HI = 1;  // Rate select, upper bit.
  localparam int unsigned CTRL_RATE_LO = 0;  // Rate select, lower bit.

  // Field positions in the serial control and status register.
  localparam int unsigned CSR_DONE     = 7;  // Transfer done flag.
  localparam int unsigned CSR_WRITE_COLLISION_FLAG     = 6;  // Write collision flag.
  localparam int unsigned CSR_OVR      = 5;  // Overrun flag.
  localparam int unsigned CSR_MODE_FAULT_FLAG     = 4;  // Mode fault flag.
  localparam int unsigned CSR_RSVD     = 3;  // Reserved, reads as zero.
  localparam int unsigned CSR_OUT_DIS  = 2;  // Output disable.
  localparam int unsigned CSR_SEL_SOFT = 1;  // Software select control.
  localparam int unsigned CSR_SEL_LVL  = 0;  // Software select level.

  // Event bit positions in the event status and mask registers.
  localparam int unsigned EVT_DONE = 0;  // Transfer finished.
  localparam int unsigned EVT_WRITE_COLLISION_FLAG = 1;  // Write collision.
  localparam int unsigned EVT_OVR  = 2;  // Overrun.
  localparam int unsigned EVT_MODE_FAULT_FLAG = 3;  // Mode fault.
  localparam int unsigned EVT_W    = 4;  // Number of event bits.

  // Reset values.
  localparam logic [7:0]       CTRL_RST     = 8'h00;  // Control register after reset.
  localparam logic [7:0]       CSR_RST      = 8'h00;  // Control and status register after reset.
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 4'h0;   // All events masked after reset.

  // Bits shifted per transfer.
  localparam logic [2:0] LAST_BIT = 3'h7;  // Index of the eighth serial clock period.

  // Master serial clock half periods, in core clock cycles.
  localparam logic [6:0] HALF_DIV4   = 7'h02;  // Core clock divided by 4.
  localparam logic [6:0] HALF_DIV8   = 7'h04;  // Core clock divided by 8.
  localparam logic [6:0] HALF_DIV16  = 7'h08;  // Core clock divided by 16.
  localparam logic [6:0] HALF_DIV32  = 7'h10;  // Core clock divided by 32.
  localparam logic [6:0] HALF_DIV64  = 7'h20;  // Core clock divided by 64.
  localparam logic [6:0] HALF_DIV128 = 7'h40;  // Core clock divided by 128.

  // Transfer engine states.
  typedef enum logic {
    XF_IDLE,  // No byte on the wire.
    XF_RUN    // A byte is being shifted.
  } ssdr_xfer_e;

endpackage
